/* shared/svl_regs.vh */
`ifndef SVL_REGS_VH
`define SVL_REGS_VH
// command codes on the instrument command port
`define SVL_CMD_RD_OPER_COND 4'h0
`define SVL_CMD_WR_OPER_MASK 4'h1
`define SVL_CMD_RD_OPER_MASK 4'h2
`define SVL_CMD_RD_OPER_EVT 4'h3
`define SVL_CMD_PRESET 4'h4
`define SVL_CMD_RD_FLT_EVT 4'h5
`define SVL_CMD_RD_FLT_COND 4'h6
`define SVL_CMD_WR_FLT_MASK 4'h7
`define SVL_CMD_RD_FLT_MASK 4'h8
`define SVL_CMD_WR_PEND_V 4'h9
`define SVL_CMD_RD_PEND_V 4'hA
`define SVL_CMD_TRIGGER 4'hB
`define SVL_CMD_WR_LIM_BOTH 4'hC
`define SVL_CMD_RD_LIM_BOTH 4'hD
`define SVL_CMD_WR_LIM_NEG 4'hE
`define SVL_CMD_WR_LIM_POS 4'hF
// operation bit positions
`define SVL_OP_LIST_ACTIVE 14
`define SVL_OP_LIST_DONE 12
`define SVL_OP_SAMPLE_DONE 11
`define SVL_OP_CONST_CURRENT 10
`define SVL_OP_PULSE_DONE 9
`define SVL_OP_CONST_VOLTAGE 8
`define SVL_OP_PULSE_PRIMED 6
`define SVL_OP_AWAIT_TRIG 5
`define SVL_OP_USED_MASK 16'h5F60
// fault bit positions
`define SVL_FT_SINKING 14
`define SVL_FT_CURRENT 13
`define SVL_FT_VOLTAGE 12
`define SVL_FT_SECONDARY 6
`define SVL_FT_THERMAL 3
`define SVL_FT_CUR_MODE 1
`define SVL_FT_VOLT_MODE 0
`define SVL_FT_USED_MASK 16'h704B
`define SVL_FT_LATCH_MASK 16'h3000
// reset and preset values
`define SVL_OP_MASK_RESET 16'h0000
`define SVL_FT_MASK_RESET 16'h0000
`define SVL_OP_MASK_PRESET 16'h2001
`define SVL_FT_MASK_PRESET 16'h00FF
`define SVL_ERR_RANGE 16'hFF22
`define SVL_ERR_NONE 16'h0000
`endif

/* design/svl_status_limits.v */
`timescale 1ns/1ps
`include "svl_regs.vh"
// Functional notes
// [R1] operation live state follows present condition
// [R2] operation bits at documented positions
// [R3] summary bit 7 is OR of enabled events
// [R4] operation mask reads back as written
// [R5] operation events latch, clear on read
// [R6] preset loads masks 8193 and 255
// [R7] only fault bits 13, 12 latch
// [R8] mode fault bits 0, 1 never latch
// [R9] fault event read clears register
// [R10] fault bits at documented positions
// [R11] fault live state, bits 1,0 both allowed
// [R12] trigger copies pending voltage to setpoint
// [R13] pending above model maximum rejected, error -222
// [R14] pending above upper limit clamps to limit
// [R15] pending voltage query returns waiting value
// [R16] combined limit sets both maxima, range checked
// [R17] combined query returns positive then negative
// [R18] negative limit command, max 1% over rated
// [R19] positive limit command, max 1% over rated
// [R20] maxima not retained without persist command
// [R21] separate limit queries return one value
// [R22] summary bit 3 is OR of enabled faults
// [R23] operation event sets on rising condition
// [R24] event in clearing read cycle survives
module svl_status_limits (
  // clock and reset
  input wire i_clock,
  input wire i_arst_n,
  // command port
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_code,
  input wire [15:0] i_cmd_data,
  input wire i_cmd_sel_neg,
  // supply live state, from outside the clock domain
  input wire [15:0] i_oper_state,
  input wire [15:0] i_fault_state,
  // model constants
  input wire [15:0] i_model_min,
  input wire [15:0] i_model_max,
  input wire [15:0] i_rated_plus_1pct,
  input wire [15:0] i_upper_voltage_limit,
  // answers
  output reg o_rsp_valid,
  output reg [15:0] o_rsp_data,
  output reg [15:0] o_rsp_data2,
  output reg o_err_valid,
  output reg [15:0] o_err_code,
  // setpoint and summaries
  output reg [15:0] o_setpoint,
  output reg [15:0] o_pos_limit_max,
  output reg [15:0] o_neg_limit_max,
  output reg o_oper_summary,
  output reg o_fault_summary
);

  // three-stage synchronisers; a change counts once stages two and three agree
  reg [15:0] op_s1_q, op_s2_q, op_s3_q, op_live_q;
  reg [15:0] ft_s1_q, ft_s2_q, ft_s3_q, ft_live_q;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_s1_q <= 16'h0000;
      op_s2_q <= 16'h0000;
      op_s3_q <= 16'h0000;
      ft_s1_q <= 16'h0000;
      ft_s2_q <= 16'h0000;
      ft_s3_q <= 16'h0000;
    end else begin
      op_s1_q <= i_oper_state;
      op_s2_q <= op_s1_q;
      op_s3_q <= op_s2_q;
      ft_s1_q <= i_fault_state;
      ft_s2_q <= ft_s1_q;
      ft_s3_q <= ft_s2_q;
    end
  end

  // per-bit agreement filter gives the live condition registers
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_live
      always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          op_live_q[gi] <= 1'b0;
          ft_live_q[gi] <= 1'b0;
        end else begin
          if (op_s2_q[gi] == op_s3_q[gi])
            op_live_q[gi] <= op_s3_q[gi]; // R1
          if (ft_s2_q[gi] == ft_s3_q[gi])
            ft_live_q[gi] <= ft_s3_q[gi]; // R11
        end
      end
    end
  endgenerate

  // unused bit positions of the condition registers always read zero
  wire [15:0] op_cond = op_live_q & `SVL_OP_USED_MASK; // R2
  wire [15:0] ft_cond = ft_live_q & `SVL_FT_USED_MASK; // R10

  // delayed copy of condition to find rising edges
  reg [15:0] op_prev_q, ft_prev_q;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_prev_q <= 16'h0000;
      ft_prev_q <= 16'h0000;
    end else begin
      op_prev_q <= op_cond;
      ft_prev_q <= ft_cond;
    end
  end

  wire [15:0] op_rise = op_cond & ~op_prev_q; // R23
  // mode fault bits are never latched, only current and voltage errors
  wire [15:0] ft_rise = ft_cond & ~ft_prev_q & `SVL_FT_LATCH_MASK; // R7 R8

  wire cmd_rd_op_evt = i_cmd_valid && (i_cmd_code == `SVL_CMD_RD_OPER_EVT);
  wire cmd_rd_ft_evt = i_cmd_valid && (i_cmd_code == `SVL_CMD_RD_FLT_EVT);
  wire cmd_preset = i_cmd_valid && (i_cmd_code == `SVL_CMD_PRESET);

  // event and mask registers
  reg [15:0] op_evt_q, op_evt_d, ft_evt_q, ft_evt_d;
  reg [15:0] op_mask_q, ft_mask_q;
  always @* begin
    // clearing read drops held bits, a same-cycle rise still lands
    op_evt_d = (cmd_rd_op_evt ? 16'h0000 : op_evt_q) | op_rise; // R5 R24
    ft_evt_d = (cmd_rd_ft_evt ? 16'h0000 : ft_evt_q) | ft_rise; // R9 R24
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_evt_q <= 16'h0000;
      ft_evt_q <= 16'h0000;
      op_mask_q <= `SVL_OP_MASK_RESET;
      ft_mask_q <= `SVL_FT_MASK_RESET;
    end else begin
      op_evt_q <= op_evt_d;
      ft_evt_q <= ft_evt_d;
      if (cmd_preset) begin
        op_mask_q <= `SVL_OP_MASK_PRESET; // R6
        ft_mask_q <= `SVL_FT_MASK_PRESET; // R6
      end else if (i_cmd_valid && i_cmd_code == `SVL_CMD_WR_OPER_MASK) begin
        op_mask_q <= i_cmd_data; // R4
      end else if (i_cmd_valid && i_cmd_code == `SVL_CMD_WR_FLT_MASK) begin
        ft_mask_q <= i_cmd_data;
      end
    end
  end

  // summaries registered from next-state so they track events exactly
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_oper_summary <= 1'b0;
      o_fault_summary <= 1'b0;
    end else begin
      o_oper_summary <= |(op_evt_d & (cmd_preset ? `SVL_OP_MASK_PRESET : op_mask_q)); // R3
      o_fault_summary <= |(ft_evt_d & (cmd_preset ? `SVL_FT_MASK_PRESET : ft_mask_q)); // R22
    end
  end

  // limit maxima and pending voltage; limits live in volatile flops only,
  // so they are lost at power-up unless the host persists them elsewhere
  reg [15:0] pend_q;
  wire lim_ok = (i_cmd_data >= i_model_min) && (i_cmd_data <= i_rated_plus_1pct);
  wire pend_over_model = i_cmd_data > i_model_max;
  wire pend_over_user = i_cmd_data > i_upper_voltage_limit;

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_q <= 16'h0000;
      o_setpoint <= 16'h0000;
      o_pos_limit_max <= 16'h0000; // R20
      o_neg_limit_max <= 16'h0000; // R20
      o_err_valid <= 1'b0;
      o_err_code <= `SVL_ERR_NONE;
    end else begin
      o_err_valid <= 1'b0;
      if (i_cmd_valid) begin
        case (i_cmd_code)
          `SVL_CMD_WR_PEND_V: begin
            if (pend_over_model) begin
              o_err_valid <= 1'b1; // R13
              o_err_code <= `SVL_ERR_RANGE; // R13
            end else if (pend_over_user) begin
              pend_q <= i_upper_voltage_limit; // R14
            end else begin
              pend_q <= i_cmd_data; // R12
            end
          end
          `SVL_CMD_TRIGGER: o_setpoint <= pend_q; // R12
          `SVL_CMD_WR_LIM_BOTH: begin
            if (lim_ok) begin
              o_pos_limit_max <= i_cmd_data; // R16
              o_neg_limit_max <= i_cmd_data; // R16
            end else begin
              o_err_valid <= 1'b1;
              o_err_code <= `SVL_ERR_RANGE;
            end
          end
          `SVL_CMD_WR_LIM_NEG: begin
            if (lim_ok)
              o_neg_limit_max <= i_cmd_data; // R18
            else begin
              o_err_valid <= 1'b1;
              o_err_code <= `SVL_ERR_RANGE;
            end
          end
          `SVL_CMD_WR_LIM_POS: begin
            if (lim_ok)
              o_pos_limit_max <= i_cmd_data; // R19
            else begin
              o_err_valid <= 1'b1;
              o_err_code <= `SVL_ERR_RANGE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // query answers, one cycle after the command
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 16'h0000;
      o_rsp_data2 <= 16'h0000;
    end else begin
      o_rsp_valid <= 1'b0;
      o_rsp_data2 <= 16'h0000;
      if (i_cmd_valid) begin
        case (i_cmd_code)
          `SVL_CMD_RD_OPER_COND: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= op_cond; // R1
          end
          `SVL_CMD_RD_OPER_MASK: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= op_mask_q; // R4
          end
          `SVL_CMD_RD_OPER_EVT: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= op_evt_q; // R5
          end
          `SVL_CMD_RD_FLT_EVT: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= ft_evt_q; // R9
          end
          `SVL_CMD_RD_FLT_COND: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= ft_cond; // R11
          end
          `SVL_CMD_RD_FLT_MASK: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= ft_mask_q;
          end
          `SVL_CMD_RD_PEND_V: begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= pend_q; // R15
          end
          `SVL_CMD_RD_LIM_BOTH: begin
            o_rsp_valid <= 1'b1;
            // data bit 0 picks a single-value query, cmd_sel_neg chooses which; else positive then negative
            if (i_cmd_data[0]) begin
              o_rsp_data <= i_cmd_sel_neg ? o_neg_limit_max : o_pos_limit_max; // R21
            end else begin
              o_rsp_data <= o_pos_limit_max; // R17
              o_rsp_data2 <= o_neg_limit_max; // R17
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule // svl_status_limits

/* bench/svl_checker.sv */
`timescale 1ns/1ps
`include "svl_regs.vh"
module svl_checker (
  // clock, reset and command
  input wire i_clock,
  input wire i_arst_n,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_code,
  input wire [15:0] i_cmd_data,
  input wire [15:0] i_model_min,
  input wire [15:0] i_model_max,
  input wire [15:0] i_rated_plus_1pct,
  // answers and stored values
  input wire o_rsp_valid,
  input wire [15:0] o_rsp_data,
  input wire [15:0] o_rsp_data2,
  input wire o_err_valid,
  input wire [15:0] o_err_code,
  input wire [15:0] o_setpoint,
  input wire [15:0] o_pos_limit_max,
  input wire [15:0] o_neg_limit_max
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // codes C, E, F write limits; D is the limit query
  wire lim_wr = i_cmd_valid && i_cmd_code >= 4'hC && i_cmd_code != 4'hD;
  wire in_win = i_cmd_data >= i_model_min && i_cmd_data <= i_rated_plus_1pct;
  wire rd_cmd = i_cmd_valid && i_cmd_code inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'hA, 4'hD};
  chk_read_answers: assert property (rd_cmd |=> o_rsp_valid)
    else $error("read gave no answer");
  chk_pos_store: assert property (lim_wr && in_win && i_cmd_code != 4'hE
    |=> o_pos_limit_max == $past(i_cmd_data)) else $error("positive limit not stored");
  chk_neg_store: assert property (lim_wr && in_win && i_cmd_code != 4'hF
    |=> o_neg_limit_max == $past(i_cmd_data)) else $error("negative limit not stored");
  chk_limit_refuse: assert property (lim_wr && !in_win |=> o_err_valid
    && o_err_code == `SVL_ERR_RANGE && $stable(o_pos_limit_max) && $stable(o_neg_limit_max))
    else $error("bad limit not refused");
  chk_pair_order: assert property (i_cmd_valid && i_cmd_code == 4'hD && !i_cmd_data[0]
    |=> o_rsp_data == o_pos_limit_max && o_rsp_data2 == o_neg_limit_max)
    else $error("limit pair wrong");
  chk_pend_reject: assert property (i_cmd_valid && i_cmd_code == 4'h9
    && i_cmd_data > i_model_max |=> o_err_valid && o_err_code == `SVL_ERR_RANGE)
    else $error("pending overrange not flagged");
  chk_setpoint_cause: assert property ($changed(o_setpoint)
    |-> $past(i_cmd_valid && i_cmd_code == 4'hB)) else $error("setpoint moved untriggered");
  chk_limit_cause: assert property ($changed(o_pos_limit_max) |-> $past(lim_wr))
    else $error("positive limit moved alone");
  cov_refuse: cover property (lim_wr && !in_win);
  cov_pair: cover property (i_cmd_valid && i_cmd_code == 4'hD);
  cov_trigger: cover property (i_cmd_valid && i_cmd_code == 4'hB);
endmodule // svl_checker
bind svl_status_limits svl_checker u_chk (.*);

/* bench/svl_host_model.sv */
`timescale 1ns/1ps
module svl_host_model (
  // clock
  input wire i_clock,
  // command port toward the register block
  output logic o_cmd_valid,
  output logic [3:0] o_cmd_code,
  output logic [15:0] o_cmd_data,
  output logic o_cmd_sel_neg
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 4'h0;
    o_cmd_data = 16'h0000;
    o_cmd_sel_neg = 1'b0;
  end
  // one strobe cycle per command, changed only on falling edges
  task automatic send(input logic [3:0] code, input logic [15:0] data, input logic neg);
    @(negedge i_clock);
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_cmd_data = data;
    o_cmd_sel_neg = neg;
    @(negedge i_clock);
    o_cmd_valid = 1'b0;
    // data no longer qualified: scramble it so nothing leans on it
    o_cmd_data = ~data;
  endtask
endmodule // svl_host_model

/* bench/tb_svl_status_limits.sv */
`timescale 1ns/1ps
`include "svl_regs.vh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_svl_status_limits;
  logic i_clock;
  logic i_arst_n;
  logic [15:0] oper;
  logic [15:0] fault;
  wire cv, sn, rv, ev, os, fs;
  wire [3:0] cc;
  wire [15:0] cd, rd, rd2, ec, sp, pl, nl;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  svl_host_model u_host (.i_clock(i_clock), .o_cmd_valid(cv), .o_cmd_code(cc),
    .o_cmd_data(cd), .o_cmd_sel_neg(sn));
  // model window: min 0x10, rated+1% 0x800, model max 0x900, user limit 0x600
  svl_status_limits u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_cmd_valid(cv),
    .i_cmd_code(cc), .i_cmd_data(cd), .i_cmd_sel_neg(sn), .i_oper_state(oper),
    .i_fault_state(fault), .i_model_min(16'h0010), .i_model_max(16'h0900),
    .i_rated_plus_1pct(16'h0800), .i_upper_voltage_limit(16'h0600), .o_rsp_valid(rv),
    .o_rsp_data(rd), .o_rsp_data2(rd2), .o_err_valid(ev), .o_err_code(ec), .o_setpoint(sp),
    .o_pos_limit_max(pl), .o_neg_limit_max(nl), .o_oper_summary(os), .o_fault_summary(fs));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task end_of_test;
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test;
    end
  end
  // query: the answer stands in the cycle after the call
  task q(input [3:0] c, input [15:0] e, input string n);
    u_host.send(c, 16'h0000, 1'b0);
    `CHK(n, e, rd)
  endtask
  initial begin
    i_arst_n = 1'b0;
    oper = 16'h0000;
    fault = 16'h0000;
    repeat (8) @(negedge i_clock);
    i_arst_n = 1'b1;
    q(`SVL_CMD_RD_OPER_MASK, 16'h0000, "mask reset");
    u_host.send(`SVL_CMD_WR_OPER_MASK, 16'hA5C3, 1'b0);
    q(`SVL_CMD_RD_OPER_MASK, 16'hA5C3, "oper mask");
    u_host.send(`SVL_CMD_PRESET, 16'h0000, 1'b0);
    q(`SVL_CMD_RD_OPER_MASK, 16'h2001, "preset oper");
    q(`SVL_CMD_RD_FLT_MASK, 16'h00FF, "preset fault");
    u_host.send(`SVL_CMD_WR_OPER_MASK, 16'h0100, 1'b0);
    oper = 16'h5F60;
    repeat (6) @(negedge i_clock);
    `CHK("oper summary", 1'b1, os)
    q(`SVL_CMD_RD_OPER_COND, 16'h5F60, "oper live");
    q(`SVL_CMD_RD_OPER_EVT, 16'h5F60, "oper events");
    q(`SVL_CMD_RD_OPER_EVT, 16'h0000, "oper cleared");
    `CHK("oper summary off", 1'b0, os)
    u_host.send(`SVL_CMD_WR_FLT_MASK, 16'h1000, 1'b0);
    fault = 16'h704B;
    repeat (6) @(negedge i_clock);
    `CHK("fault summary", 1'b1, fs)
    q(`SVL_CMD_RD_FLT_COND, 16'h704B, "fault live");
    q(`SVL_CMD_RD_FLT_EVT, 16'h3000, "fault events");
    q(`SVL_CMD_RD_FLT_EVT, 16'h0000, "fault cleared");
    u_host.send(`SVL_CMD_WR_LIM_BOTH, 16'h0500, 1'b0);
    q(`SVL_CMD_RD_LIM_BOTH, 16'h0500, "both pos");
    `CHK("both neg", 16'h0500, rd2)
    u_host.send(`SVL_CMD_WR_LIM_NEG, 16'h0800, 1'b0);
    u_host.send(`SVL_CMD_WR_LIM_POS, 16'h0010, 1'b0);
    u_host.send(`SVL_CMD_RD_LIM_BOTH, 16'h0001, 1'b1);
    `CHK("neg single", 16'h0800, rd)
    `CHK("answer valid", 1'b1, rv)
    `CHK("neg stored", 16'h0800, nl)
    u_host.send(`SVL_CMD_RD_LIM_BOTH, 16'h0001, 1'b0);
    `CHK("pos single", 16'h0010, rd)
    u_host.send(`SVL_CMD_WR_LIM_POS, 16'h0801, 1'b0);
    `CHK("limit error", 16'hFF22, ec)
    `CHK("limit err pulse", 1'b1, ev)
    `CHK("no answer on write", 1'b0, rv)
    `CHK("pos kept", 16'h0010, pl)
    u_host.send(`SVL_CMD_WR_PEND_V, 16'h0400, 1'b0);
    q(`SVL_CMD_RD_PEND_V, 16'h0400, "pending");
    u_host.send(`SVL_CMD_TRIGGER, 16'h0000, 1'b0);
    `CHK("setpoint", 16'h0400, sp)
    u_host.send(`SVL_CMD_WR_PEND_V, 16'h0700, 1'b0);
    q(`SVL_CMD_RD_PEND_V, 16'h0600, "clamped");
    u_host.send(`SVL_CMD_WR_PEND_V, 16'h0A00, 1'b0);
    `CHK("pend error", 1'b1, ev)
    q(`SVL_CMD_RD_PEND_V, 16'h0600, "pend kept");
    end_of_test;
  end
endmodule // tb_svl_status_limits
